// ==== ptp_clock_adjust_and_timestamping.sv ====
// time counter with rate adjustment, ptp ingress filter and egress timestamping
//
// Function
// RL1 - nanoseconds advance by 39, 40 or 41 every 40ns tick
// RL2 - continuous mode adjusts sub-nanoseconds by rate every tick
// RL3 - direction bit zero adds the rate, one subtracts it
// RL4 - rate counts in 2^-32 ns per 40ns tick
// RL5 - correction starts on the tick after the rate write
// RL6 - clearing continuous bit or zero rate stops correction
// RL7 - temporary mode runs for programmed duration, counter then rests at zero
// RL8 - temporary bit reads one while running, clears itself when done
// RL9 - software sets temporary bit again to reload rate and duration
// RL10 - software writes duration and rate low before rate high
// RL11 - software resets counter, loads start value, then enables it
// RL12 - ptp processing only when enabled, per enabled encapsulation; egress ignores encapsulation, correction and checksum edits ungated
// RL13 - ipv4 checksum recalculated or zeroed as set, ipv6 always updated
// RL14 - receive timestamp captured at start-of-frame delimiter
// RL15 - receive latency and asymmetry never applied to captured timestamps
// RL16 - ingress timestamp and port embedded in received header
// RL17 - drop wrong domain or version, never forward version one
// RL18 - unpaired messages withheld from host when filter enabled
// RL19 - ptp frames go to the highest priority egress queue
// RL20 - correction field gets residence, link delay or turnaround time
// RL21 - reserved header fields cleared before transmit
// RL22 - one-step mode inserts origin timestamp into sync
// RL23 - egress timestamps latched per type, status set, interrupt if enabled
// RL24 - transmit latency added to latched egress timestamps
// RL25 - asymmetry subtracted from correction of delay and peer delay requests
`timescale 1ns/1ps
`default_nettype none

module ptp_clock_adjust_and_timestamping #(
  parameter int ADDR_W = 14
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_sfd,
  input  wire logic              rx_hdr_valid,
  input  wire ptp_pkg::rx_hdr_t  rx_hdr,
  output ptp_pkg::rx_res_t       rx_res,
  input  wire logic              tx_req,
  input  wire ptp_pkg::tx_hdr_t  tx_hdr,
  output ptp_pkg::tx_res_t       tx_res,
  input  wire logic              tx_sent,
  input  wire logic [3:0]        tx_sent_type,
  output logic                   ts_irq
);

  typedef struct packed {
    logic [7:0]       tick_cnt;
    logic [5:0]       ctrl;
    logic [29:0]      load_ns;
    logic [31:0]      load_s;
    logic [31:0]      rate;
    logic [31:0]      dur;
    logic [31:0]      dur_cnt;
    logic [31:0]      rate_int;
    logic [31:0]      sec;
    logic [29:0]      ns;
    logic [31:0]      subns;
    logic [15:0]      cfg1;
    logic [15:0]      cfg2;
    logic [15:0]      domver;
    logic [15:0]      tx_lat;
    logic [15:0]      asym;
    logic [15:0]      link;
    logic [31:0]      dreq_ts;
    logic [31:0]      sync_ts;
    logic [31:0]      pdresp_ts;
    logic [2:0]       ts_is;
    logic [2:0]       ts_ie;
    logic [31:0]      sfd_sec;
    logic [29:0]      sfd_ns;
    ptp_pkg::rx_res_t rx;
    ptp_pkg::tx_res_t tx;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } state_t;

  state_t      st_ff;
  state_t      nxt_st;
  logic        tick;
  logic        run;
  logic        adj;
  logic [31:0] rate_use;
  logic [32:0] sub_sum;
  logic [31:0] ns_sum;
  logic [11:0] idx;
  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd;
  logic        enc_on;
  logic        proc;
  logic        paired;
  logic [31:0] lat32;
  logic [2:0]  ts_set;

  // ************************************************************
  // combinational helpers
  // ************************************************************
  // word index from byte address; accesses complete on the ready cycle
  always_comb
  begin
    idx  = 12'(paddr >> 2);
    acc  = psel & penable & st_ff.pready;
    wr   = acc & pwrite;
    run  = st_ff.ctrl[ptp_pkg::CTL_RUN_N] & st_ff.ctrl[ptp_pkg::CTL_EN];
    tick = run && (st_ff.tick_cnt == 8'(ptp_pkg::TICK_CYC - 1));
    proc = st_ff.cfg1[ptp_pkg::CF1_PTP_EN] & st_ff.cfg1[ptp_pkg::CF1_DET_EN]; // RL12
    lat32 = {16'h0000, st_ff.tx_lat};
  end

  // rate step: temporary mode uses its private copy, zero rate leaves the sub-nanoseconds untouched
  always_comb
  begin
    adj      = st_ff.ctrl[ptp_pkg::CTL_TEMP] ? (st_ff.dur_cnt != 32'h0) :
               st_ff.ctrl[ptp_pkg::CTL_CONT]; // RL6 RL7
    rate_use = st_ff.ctrl[ptp_pkg::CTL_TEMP] ? st_ff.rate_int : st_ff.rate;
    if (!adj)
      sub_sum = {1'b0, st_ff.subns};
    else if (st_ff.ctrl[ptp_pkg::CTL_DIR])
      sub_sum = {1'b0, st_ff.subns} - {1'b0, rate_use}; // RL3
    else
      sub_sum = {1'b0, st_ff.subns} + {1'b0, rate_use}; // RL2 RL4
    // carry or borrow moves the nanosecond step to 41 or 39
    if (!sub_sum[32])
      ns_sum = {2'b00, st_ff.ns} + ptp_pkg::NS_STEP; // RL1
    else if (st_ff.ctrl[ptp_pkg::CTL_DIR])
      ns_sum = {2'b00, st_ff.ns} + ptp_pkg::NS_STEP - 32'h1;
    else
      ns_sum = {2'b00, st_ff.ns} + ptp_pkg::NS_STEP + 32'h1;
  end

  // encapsulation enable and pairing check for the received header
  always_comb
  begin
    case (rx_hdr.encap)
      ptp_pkg::ENC_ETH:  enc_on = st_ff.cfg1[ptp_pkg::CF1_ETH];
      ptp_pkg::ENC_IPV4: enc_on = st_ff.cfg1[ptp_pkg::CF1_IPV4];
      ptp_pkg::ENC_IPV6: enc_on = st_ff.cfg1[ptp_pkg::CF1_IPV6];
      default:           enc_on = 1'b0;
    endcase
    paired = rx_hdr.msg_type inside {ptp_pkg::MT_SYNC, ptp_pkg::MT_DREQ,
             ptp_pkg::MT_PDREQ, ptp_pkg::MT_PDRESP, ptp_pkg::MT_FUP,
             ptp_pkg::MT_DRESP}; // RL18
  end

  // read mux; the live counter is shown at the load offsets
  always_comb
  begin
    hit = 1'b1;
    rd  = 32'h0;
    case (idx)
      ptp_pkg::IDX_CTRL:      rd = {26'h0, st_ff.ctrl};
      ptp_pkg::IDX_LOAD_NS:   rd = {2'b00, st_ff.ns};
      ptp_pkg::IDX_LOAD_S:    rd = st_ff.sec;
      ptp_pkg::IDX_RATE:      rd = st_ff.rate;
      ptp_pkg::IDX_DUR:       rd = st_ff.dur;
      ptp_pkg::IDX_CFG1:      rd = {16'h0, st_ff.cfg1};
      ptp_pkg::IDX_CFG2:      rd = {16'h0, st_ff.cfg2};
      ptp_pkg::IDX_DOMVER:    rd = {16'h0, st_ff.domver};
      ptp_pkg::IDX_TX_LAT:    rd = {16'h0, st_ff.tx_lat};
      ptp_pkg::IDX_ASYM:      rd = {16'h0, st_ff.asym};
      ptp_pkg::IDX_LINK:      rd = {16'h0, st_ff.link};
      ptp_pkg::IDX_DREQ_TS:   rd = st_ff.dreq_ts;
      ptp_pkg::IDX_SYNC_TS:   rd = st_ff.sync_ts;
      ptp_pkg::IDX_PDRESP_TS: rd = st_ff.pdresp_ts;
      ptp_pkg::IDX_TS_IS:     rd = {29'h0, st_ff.ts_is};
      ptp_pkg::IDX_TS_IE:     rd = {29'h0, st_ff.ts_ie};
      default:                hit = 1'b0;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    // bus answer: ready one cycle after setup, data sampled in setup
    nxt_st.pready  = psel & ~penable;
    nxt_st.prdata  = (psel & ~penable & ~pwrite) ? rd : 32'h0;
    nxt_st.pslverr = psel & ~penable & ~hit;
    nxt_st.ctrl[ptp_pkg::CTL_LOAD] = 1'b0;
    nxt_st.tick_cnt = (!run || tick) ? 8'h00 : st_ff.tick_cnt + 8'h01;

    // time counter advance, temporary duration countdown
    if (tick)
    begin
      nxt_st.subns = sub_sum[31:0];
      if (ns_sum >= ptp_pkg::NS_PER_SEC)
      begin
        nxt_st.ns  = 30'(ns_sum - ptp_pkg::NS_PER_SEC);
        nxt_st.sec = st_ff.sec + 32'h1;
      end
      else
        nxt_st.ns = ns_sum[29:0];
      if (st_ff.ctrl[ptp_pkg::CTL_TEMP])
      begin
        if (st_ff.dur_cnt > 32'h1)
          nxt_st.dur_cnt = st_ff.dur_cnt - 32'h1; // RL7
        else
        begin
          nxt_st.dur_cnt = 32'h0; // RL7
          nxt_st.ctrl[ptp_pkg::CTL_TEMP] = 1'b0; // RL8
        end
      end
    end

    // register writes; rate takes effect on the next tick, in temporary mode only once the temporary bit is set again
    if (wr && hit)
    begin
      case (idx)
        ptp_pkg::IDX_CTRL:
        begin
          nxt_st.ctrl[4:0] = pwdata[4:0];
          nxt_st.ctrl[ptp_pkg::CTL_TEMP] = pwdata[ptp_pkg::CTL_TEMP] |
                                           nxt_st.ctrl[ptp_pkg::CTL_TEMP];
          if (pwdata[ptp_pkg::CTL_TEMP])
          begin
            nxt_st.dur_cnt  = st_ff.dur; // RL9
            nxt_st.rate_int = st_ff.rate;
          end
          if (pwdata[ptp_pkg::CTL_LOAD])
          begin
            nxt_st.ns    = st_ff.load_ns;
            nxt_st.sec   = st_ff.load_s;
            nxt_st.subns = 32'h0;
          end
        end
        ptp_pkg::IDX_LOAD_NS: nxt_st.load_ns = pwdata[29:0];
        ptp_pkg::IDX_LOAD_S:  nxt_st.load_s  = pwdata;
        ptp_pkg::IDX_RATE:    nxt_st.rate    = pwdata; // RL5
        ptp_pkg::IDX_DUR:     nxt_st.dur     = pwdata;
        ptp_pkg::IDX_CFG1:    nxt_st.cfg1    = pwdata[15:0];
        ptp_pkg::IDX_CFG2:    nxt_st.cfg2    = pwdata[15:0];
        ptp_pkg::IDX_DOMVER:  nxt_st.domver  = pwdata[15:0];
        ptp_pkg::IDX_TX_LAT:  nxt_st.tx_lat  = pwdata[15:0];
        ptp_pkg::IDX_ASYM:    nxt_st.asym    = pwdata[15:0];
        ptp_pkg::IDX_LINK:    nxt_st.link    = pwdata[15:0];
        ptp_pkg::IDX_TS_IE:   nxt_st.ts_ie   = pwdata[2:0];
        default:              nxt_st.ctrl    = st_ff.ctrl;
      endcase
    end

    // a counter held in reset this cycle and the next is zeroed whatever else happens
    if (!st_ff.ctrl[ptp_pkg::CTL_RUN_N] && !nxt_st.ctrl[ptp_pkg::CTL_RUN_N])
    begin
      nxt_st.ns    = 30'h0;
      nxt_st.sec   = 32'h0;
      nxt_st.subns = 32'h0;
    end

    // ingress: raw timestamp at the delimiter, no latency applied
    if (rx_sfd)
    begin
      nxt_st.sfd_sec = st_ff.sec; // RL14 RL15
      nxt_st.sfd_ns  = st_ff.ns;
    end
    nxt_st.rx.valid = rx_hdr_valid;
    if (rx_hdr_valid)
    begin
      nxt_st.rx.is_ptp  = proc & enc_on; // RL12
      nxt_st.rx.forward = !(proc & enc_on) ||
                          ((rx_hdr.domain == st_ff.domver[7:0]) &&
                           (rx_hdr.version == st_ff.domver[11:8]) &&
                           (rx_hdr.version != 4'h1) &&
                           (paired || !st_ff.cfg2[ptp_pkg::CF2_PAIR])); // RL17 RL18
      nxt_st.rx.port = ptp_pkg::PORT_NUM; // RL16
      nxt_st.rx.sec  = st_ff.sfd_sec;
      nxt_st.rx.ns   = st_ff.sfd_ns;
    end

    // egress header edit, one cycle after the request
    nxt_st.tx.valid = tx_req;
    if (tx_req)
    begin
      nxt_st.tx.high_prio  = proc; // RL19
      nxt_st.tx.clear_rsvd = proc; // RL21
      nxt_st.tx.insert_origin = proc && st_ff.cfg1[ptp_pkg::CF1_ONESTEP] &&
                                (tx_hdr.msg_type == ptp_pkg::MT_SYNC); // RL22
      nxt_st.tx.origin_sec = st_ff.sec;
      nxt_st.tx.origin_ns  = st_ff.ns;
      case (tx_hdr.encap)
        ptp_pkg::ENC_IPV4: nxt_st.tx.csum_op = st_ff.cfg1[ptp_pkg::CF1_CSUM_RC] ?
                             ptp_pkg::CSUM_RECALC : ptp_pkg::CSUM_ZERO; // RL13
        ptp_pkg::ENC_IPV6: nxt_st.tx.csum_op = ptp_pkg::CSUM_RECALC; // RL13
        default:           nxt_st.tx.csum_op = ptp_pkg::CSUM_KEEP;
      endcase
      case (tx_hdr.corr_op)
        ptp_pkg::CORR_LINK: nxt_st.tx.correction = tx_hdr.correction +
                              {16'h0000, st_ff.link}; // RL20
        ptp_pkg::CORR_NONE: nxt_st.tx.correction = tx_hdr.correction;
        default:            nxt_st.tx.correction = tx_hdr.correction +
                              tx_hdr.add_time; // RL20
      endcase
      if (tx_hdr.msg_type == ptp_pkg::MT_DREQ || tx_hdr.msg_type == ptp_pkg::MT_PDREQ)
        nxt_st.tx.correction = nxt_st.tx.correction - {16'h0000, st_ff.asym}; // RL25
    end

    // egress timestamp latches referenced to the wire
    ts_set = 3'h0;
    if (tx_sent)
    begin
      case (tx_sent_type)
        ptp_pkg::MT_SYNC:
        begin
          nxt_st.sync_ts = {2'b00, st_ff.ns} + lat32; // RL23 RL24
          ts_set[ptp_pkg::TS_SYNC] = 1'b1;
        end
        ptp_pkg::MT_DREQ, ptp_pkg::MT_PDREQ:
        begin
          nxt_st.dreq_ts = {2'b00, st_ff.ns} + lat32; // RL23 RL24
          ts_set[ptp_pkg::TS_DREQ] = 1'b1;
        end
        ptp_pkg::MT_PDRESP:
        begin
          nxt_st.pdresp_ts = {2'b00, st_ff.ns} + lat32; // RL23 RL24
          ts_set[ptp_pkg::TS_PDRESP] = 1'b1;
        end
        default: ts_set = 3'h0;
      endcase
    end
    // write-one-to-clear; a new latch in the same cycle wins
    if (wr && idx == ptp_pkg::IDX_TS_IS)
      nxt_st.ts_is = (st_ff.ts_is & ~pwdata[2:0]) | ts_set; // RL23
    else
      nxt_st.ts_is = st_ff.ts_is | ts_set; // RL23
    nxt_st.irq = |(nxt_st.ts_is & nxt_st.ts_ie); // RL23
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff        <= '0;
      st_ff.ctrl   <= ptp_pkg::CTRL_RST;
      st_ff.cfg1   <= ptp_pkg::CFG_RST;
      st_ff.domver <= ptp_pkg::DOMVER_RST;
    end
    else
      st_ff <= nxt_st;
  end

  assign prdata  = st_ff.prdata;
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign rx_res  = st_ff.rx;
  assign tx_res  = st_ff.tx;
  assign ts_irq  = st_ff.irq;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ns_step_size: assert property (tick && !wr && st_ff.ns < 30'd999999000 |=> // RL1
    (st_ff.ns - $past(st_ff.ns)) inside {30'd39, 30'd40, 30'd41})
    else $error("nanosecond step outside 39..41");
  a_rate_add_dir: assert property (tick && !wr && st_ff.ctrl[3] && !st_ff.ctrl[5] && // RL3
    !st_ff.ctrl[4] |=> st_ff.subns == $past(st_ff.subns) + $past(st_ff.rate))
    else $error("positive rate not added");
  a_rate_sub_dir: assert property (tick && !wr && st_ff.ctrl[3] && !st_ff.ctrl[5] && // RL2
    st_ff.ctrl[4] |=> st_ff.subns == $past(st_ff.subns) - $past(st_ff.rate))
    else $error("negative rate not subtracted");
  a_no_adjust: assert property (tick && !wr && !st_ff.ctrl[3] && !st_ff.ctrl[5] |=> // RL6
    $stable(st_ff.subns) ##0 st_ff.ns != $past(st_ff.ns))
    else $error("adjustment without mode");
  a_temp_done: assert property (tick && !wr && st_ff.ctrl[5] && st_ff.dur_cnt == 32'h1 |=> // RL8
    !st_ff.ctrl[5] && st_ff.dur_cnt == 32'h0)
    else $error("temporary adjust did not finish");
  a_dur_rest: assert property (!st_ff.ctrl[5] && st_ff.dur_cnt == 32'h0 && !wr |=> // RL7
    st_ff.dur_cnt == 32'h0)
    else $error("duration counter left zero");
  a_rx_ts_raw: assert property (rx_sfd ##1 (rx_hdr_valid && !rx_sfd) |=> // RL14
    rx_res.valid && rx_res.ns == $past(st_ff.ns, 2))
    else $error("receive timestamp not from delimiter");
  a_rx_v1_drop: assert property (rx_hdr_valid && proc && enc_on && rx_hdr.version == 4'h1 // RL17
    |=> rx_res.valid && !rx_res.forward)
    else $error("version one frame forwarded");
  a_asym_sub: assert property (tx_req && tx_hdr.msg_type == 4'h1 && // RL25
    tx_hdr.corr_op == ptp_pkg::CORR_NONE |=> tx_res.correction ==
    $past(tx_hdr.correction) - {16'h0000, $past(st_ff.asym)})
    else $error("asymmetry not subtracted");
  a_sync_latch: assert property (tx_sent && tx_sent_type == 4'h0 |=> // RL24
    st_ff.sync_ts == {2'b00, $past(st_ff.ns)} + {16'h0000, $past(st_ff.tx_lat)} ##0
    st_ff.ts_is[0] ##1 (ts_irq || !st_ff.ts_ie[0] || !st_ff.ts_is[0]))
    else $error("sync egress latch wrong");

  c_temp_run: cover property (st_ff.ctrl[5] ##1 !st_ff.ctrl[5]);
  c_rx_drop:  cover property (rx_res.valid && rx_res.is_ptp && !rx_res.forward);
  c_one_step: cover property (tx_res.valid && tx_res.insert_origin);
  c_irq_rise: cover property (!ts_irq ##1 ts_irq);

endmodule

`default_nettype wire

// ==== ptp_clock_adjust_and_timestamping_bench.sv ====
// self-checking bench of the precision-time block against the remote peer model
`timescale 1ns/1ps
`default_nettype none

module ptp_clock_adjust_and_timestamping_bench;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
  logic             tx_req, rx_sfd, rx_hdr_valid, tx_sent, ts_irq;
  logic [13:0]      paddr;
  logic [31:0]      pwdata, prdata, rd_v, a, lat, lk, asy, cf;
  logic [3:0]       tx_sent_type;
  ptp_pkg::rx_hdr_t rx_hdr, h;
  ptp_pkg::rx_res_t rx_res;
  ptp_pkg::tx_hdr_t tx_hdr, t;
  ptp_pkg::tx_res_t tx_res;
  int               mismatches, compares, cyc, seed;
  logic [3:0]       st[3] = '{ptp_pkg::MT_SYNC, ptp_pkg::MT_PDREQ, ptp_pkg::MT_PDRESP};
  logic [11:0]      sr[3] = '{ptp_pkg::IDX_SYNC_TS, ptp_pkg::IDX_DREQ_TS, ptp_pkg::IDX_PDRESP_TS};
  logic [31:0]      rt[4] = '{32'h0, 32'h80000000, 32'h80000000, 32'h80000000};
  logic [31:0]      ct[4] = '{32'h0B, 32'h0B, 32'h1B, 32'h03};
  logic [31:0]      dt[4] = '{32'd400, 32'd405, 32'd395, 32'd400};
  logic [3:0]       ty[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};

  ptp_clock_adjust_and_timestamping ptp_clock_adjust_and_timestamping_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_sfd(rx_sfd),
    .rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr), .rx_res(rx_res), .tx_req(tx_req),
    .tx_hdr(tx_hdr), .tx_res(tx_res), .tx_sent(tx_sent), .tx_sent_type(tx_sent_type),
    .ts_irq(ts_irq));
  ptp_remote_peer ptp_remote_peer_i (.pclk(pclk), .rx_sfd(rx_sfd), .rx_hdr_valid(rx_hdr_valid),
    .rx_hdr(rx_hdr), .tx_sent(tx_sent), .tx_sent_type(tx_sent_type));

  always #2 pclk = ~pclk;

  // hang guard, far above the roughly 1060 cycles the tests need
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask

  // one apb transfer of three cycles, the request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic fwd_exp(ptp_pkg::rx_hdr_t x, logic p);
    return x.domain == 8'h05 && x.version == 4'h2 && (!p || x.msg_type inside {ty});
  endfunction

  function automatic logic [31:0] corr_exp(ptp_pkg::tx_hdr_t x);
    logic [31:0] c;
    c = x.correction;
    if (x.corr_op == ptp_pkg::CORR_RESID || x.corr_op == ptp_pkg::CORR_TURN)
      c = c + x.add_time;
    if (x.corr_op == ptp_pkg::CORR_LINK)
      c = c + lk;
    if (x.msg_type == ptp_pkg::MT_DREQ || x.msg_type == ptp_pkg::MT_PDREQ)
      c = c - asy;
    return c;
  endfunction

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, tx_req} = 6'h00;
    {paddr, pwdata, tx_hdr} = '0;
    seed = 32'h061a;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ptp_pkg::IDX_DOMVER, 0);
    chk("domver", rd_v, 32'h00000200);
    apb(1, 12'h7FF, 32'hFFFFFFFF);
    chk("unmapped err", rd_e, 1);
    apb(0, 12'h7FF, 0);
    chk("unmapped data", rd_v, 0);
    $display("test registers done");
    // counter still held at zero, so each latched time is the transmit latency alone
    lat = $random(seed) & 32'hFFFF;
    apb(1, ptp_pkg::IDX_TX_LAT, lat);
    apb(1, ptp_pkg::IDX_TS_IE, 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      ptp_remote_peer_i.sent(st[k]);
      @(negedge pclk);
      chk("irq", ts_irq, 1);
      @(posedge pclk);
      apb(0, sr[k], 0);
      chk("egress time", rd_v, lat);
      apb(0, ptp_pkg::IDX_TS_IS, 0);
      chk("status", rd_v, (32'h2 << k) - 1);
    end
    apb(1, ptp_pkg::IDX_TS_IS, 32'h7);
    ptp_remote_peer_i.sent(ptp_pkg::MT_DREQ);
    @(negedge pclk);
    chk("masked irq", ts_irq, 0);
    @(posedge pclk);
    $display("test egress latch done");
    apb(1, ptp_pkg::IDX_CTRL, 0);
    apb(1, ptp_pkg::IDX_LOAD_S, 7);
    apb(1, ptp_pkg::IDX_CTRL, 32'h5);
    apb(0, ptp_pkg::IDX_LOAD_S, 0);
    chk("loaded sec", rd_v, 7);
    // reads exactly 100 cycles apart span ten ticks; half-ns rate carries on every other tick
    for (int k = 0; k < 4; k++)
    begin
      apb(1, ptp_pkg::IDX_RATE, rt[k]);
      apb(1, ptp_pkg::IDX_CTRL, ct[k]);
      apb(0, ptp_pkg::IDX_LOAD_NS, 0);
      a = rd_v;
      repeat (97) @(posedge pclk);
      apb(0, ptp_pkg::IDX_LOAD_NS, 0);
      chk("ns advance", rd_v - a, dt[k]);
    end
    apb(1, ptp_pkg::IDX_DUR, 2);
    apb(1, ptp_pkg::IDX_RATE, rt[3]);
    apb(0, ptp_pkg::IDX_LOAD_NS, 0);
    a = rd_v;
    apb(1, ptp_pkg::IDX_CTRL, 32'h23);
    apb(0, ptp_pkg::IDX_CTRL, 0);
    chk("temp running", rd_v[5], 1);
    repeat (91) @(posedge pclk);
    apb(0, ptp_pkg::IDX_LOAD_NS, 0);
    chk("temp advance", rd_v - a, 401);
    apb(0, ptp_pkg::IDX_CTRL, 0);
    chk("temp done", rd_v[5], 0);
    $display("test time counter done");
    h = '{4'h0, 2'h0, 8'h05, 4'h2};
    ptp_remote_peer_i.send_frame(h);
    @(negedge pclk);
    chk("off is_ptp", rx_res.is_ptp, 0);
    chk("off forward", rx_res.forward, 1);
    @(posedge pclk);
    apb(1, ptp_pkg::IDX_CFG1, 32'h1F);
    apb(1, ptp_pkg::IDX_DOMVER, 32'h205);
    for (int i = 0; i < 40; i++)
    begin
      apb(1, ptp_pkg::IDX_CFG2, i & 1);
      h = '{$random(seed), {$random(seed)} % 3, ($random(seed) & 1) ? 8'h05 : $random(seed),
            $random(seed) & 3};
      ptp_remote_peer_i.send_frame(h);
      @(negedge pclk);
      chk("rx valid", {rx_res.valid, rx_res.is_ptp, rx_res.port, rx_res.sec[27:0]},
          32'hD0000007);
      chk("rx forward", rx_res.forward, fwd_exp(h, i[0]));
      @(posedge pclk);
    end
    $display("test ingress done");
    lk = $random(seed) & 32'hFFFF;
    asy = $random(seed) & 32'hFFFF;
    apb(1, ptp_pkg::IDX_LINK, lk);
    apb(1, ptp_pkg::IDX_ASYM, asy);
    for (int i = 0; i < 40; i++)
    begin
      if (i % 10 == 0)
        cf = {$random(seed)} % 4;
      apb(1, ptp_pkg::IDX_CFG1, {cf[1:0], 5'h1F});
      t = '{ty[{$random(seed)} % 6], {$random(seed)} % 3, ptp_pkg::corr_op_t'($random(seed)),
            $random(seed), $random(seed)};
      tx_req <= 1'b1;
      tx_hdr <= t;
      @(posedge pclk);
      tx_req <= 1'b0;
      tx_hdr <= ~t;
      @(negedge pclk);
      chk("tx flags", {tx_res.valid, tx_res.high_prio, tx_res.clear_rsvd,
          tx_res.origin_sec[28:0]}, 32'hE0000007);
      chk("origin", tx_res.insert_origin, cf[0] && t.msg_type == 4'h0);
      chk("csum", tx_res.csum_op, t.encap == 2'h0 ? 0 : (t.encap == 2'h1 && !cf[1]) ? 2 : 1);
      chk("correction", tx_res.correction, corr_exp(t));
      @(posedge pclk);
    end
    $display("test egress done");
    test_done();
  end
endmodule

`default_nettype wire

// ==== ptp_pkg.sv ====
// constants, register map and carrier types of the precision-time block
package ptp_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_NS       = 40;
  localparam int TICK_CYC      = (TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
  localparam logic [31:0] NS_STEP    = 32'h00000028;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [11:0] IDX_CTRL      = 12'h600;
  localparam logic [11:0] IDX_LOAD_NS   = 12'h604;
  localparam logic [11:0] IDX_LOAD_S    = 12'h608;
  localparam logic [11:0] IDX_RATE      = 12'h610;
  localparam logic [11:0] IDX_DUR       = 12'h614;
  localparam logic [11:0] IDX_CFG1      = 12'h620;
  localparam logic [11:0] IDX_CFG2      = 12'h622;
  localparam logic [11:0] IDX_DOMVER    = 12'h624;
  localparam logic [11:0] IDX_TX_LAT    = 12'h640;
  localparam logic [11:0] IDX_ASYM      = 12'h644;
  localparam logic [11:0] IDX_LINK      = 12'h646;
  localparam logic [11:0] IDX_DREQ_TS   = 12'h648;
  localparam logic [11:0] IDX_SYNC_TS   = 12'h64C;
  localparam logic [11:0] IDX_PDRESP_TS = 12'h650;
  localparam logic [11:0] IDX_TS_IS     = 12'h68C;
  localparam logic [11:0] IDX_TS_IE     = 12'h68E;

  // control register fields
  localparam int CTL_RUN_N = 0;
  localparam int CTL_EN    = 1;
  localparam int CTL_LOAD  = 2;
  localparam int CTL_CONT  = 3;
  localparam int CTL_DIR   = 4;
  localparam int CTL_TEMP  = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // message configuration fields
  localparam int CF1_PTP_EN  = 0;
  localparam int CF1_DET_EN  = 1;
  localparam int CF1_ETH     = 2;
  localparam int CF1_IPV4    = 3;
  localparam int CF1_IPV6    = 4;
  localparam int CF1_ONESTEP = 5;
  localparam int CF1_CSUM_RC = 6;
  localparam int CF2_PAIR    = 0;
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam logic [15:0] DOMVER_RST = 16'h0200;

  // timestamp status bits
  localparam int TS_SYNC   = 0;
  localparam int TS_DREQ   = 1;
  localparam int TS_PDRESP = 2;

  // message types and encapsulations
  localparam logic [3:0] MT_SYNC   = 4'h0;
  localparam logic [3:0] MT_DREQ   = 4'h1;
  localparam logic [3:0] MT_PDREQ  = 4'h2;
  localparam logic [3:0] MT_PDRESP = 4'h3;
  localparam logic [3:0] MT_FUP    = 4'h8;
  localparam logic [3:0] MT_DRESP  = 4'h9;
  localparam logic [1:0] ENC_ETH   = 2'h0;
  localparam logic [1:0] ENC_IPV4  = 2'h1;
  localparam logic [1:0] ENC_IPV6  = 2'h2;
  localparam logic [1:0] PORT_NUM  = 2'h1;

  typedef enum logic [1:0] {CORR_NONE, CORR_RESID, CORR_LINK, CORR_TURN} corr_op_t;
  typedef enum logic [1:0] {CSUM_KEEP, CSUM_RECALC, CSUM_ZERO} csum_op_t;

  typedef struct packed {
    logic [3:0] msg_type;
    logic [1:0] encap;
    logic [7:0] domain;
    logic [3:0] version;
  } rx_hdr_t;

  typedef struct packed {
    logic        valid;
    logic        is_ptp;
    logic        forward;
    logic [1:0]  port;
    logic [31:0] sec;
    logic [29:0] ns;
  } rx_res_t;

  typedef struct packed {
    logic [3:0]  msg_type;
    logic [1:0]  encap;
    corr_op_t    corr_op;
    logic [31:0] correction;
    logic [31:0] add_time;
  } tx_hdr_t;

  typedef struct packed {
    logic        valid;
    logic        high_prio;
    logic        clear_rsvd;
    logic        insert_origin;
    csum_op_t    csum_op;
    logic [31:0] correction;
    logic [31:0] origin_sec;
    logic [29:0] origin_ns;
  } tx_res_t;

endpackage

// ==== ptp_remote_peer.sv ====
// remote ptp peer model: sends frames toward the block and reports finished transmits
`timescale 1ns/1ps
`default_nettype none

module ptp_remote_peer (
  input  wire logic        pclk,
  output logic             rx_sfd,
  output logic             rx_hdr_valid,
  output ptp_pkg::rx_hdr_t rx_hdr,
  output logic             tx_sent,
  output logic [3:0]       tx_sent_type
);
  // quiet line at time zero
  initial
  begin
    rx_sfd = 1'b0;
    rx_hdr_valid = 1'b0;
    rx_hdr = '0;
    tx_sent = 1'b0;
    tx_sent_type = 4'h0;
  end

  // delimiter first, header a cycle later; a stale header is inverted so it never passes as live
  task automatic send_frame(input ptp_pkg::rx_hdr_t h);
    rx_sfd <= 1'b1;
    @(posedge pclk);
    rx_sfd <= 1'b0;
    rx_hdr_valid <= 1'b1;
    rx_hdr <= h;
    @(posedge pclk);
    rx_hdr_valid <= 1'b0;
    rx_hdr <= ~h;
  endtask

  // one-cycle completion pulse carrying the type of the frame that left
  task automatic sent(input logic [3:0] t);
    tx_sent <= 1'b1;
    tx_sent_type <= t;
    @(posedge pclk);
    tx_sent <= 1'b0;
    tx_sent_type <= ~t;
  endtask
endmodule

`default_nettype wire
